// *** rtl/ogb_pkg.sv ***
// Shared constants, modes and carriers for the output serializer gearbox
package ogb_pkg;

  // Parallel word width from the core and serial framing lengths
  localparam int unsigned OGB_WORD_W     = 8;
  localparam int unsigned OGB_FIFO_DEPTH = 16;
  localparam logic [2:0]  OGB_LAST_SEVEN = 3'h6;  // Bit index of final bit, 7:1
  localparam logic [2:0]  OGB_LAST_EIGHT = 3'h7;  // Bit index of final bit, 8:1
  localparam logic [2:0]  OGB_LAST_FOUR  = 3'h3;  // Bit index of final bit, 4:1
  localparam int unsigned OGB_LANE_B_LSB = 4;     // Second gearbox takes bits 7:4

  // Reset values of the pipeline
  localparam logic [7:0]  OGB_WORD_RST   = 8'h00;
  localparam logic [2:0]  OGB_CNT_RST    = 3'h0;
  localparam logic        OGB_IDLE_BIT   = 1'b0;

  // Gearing modes
  typedef enum logic [1:0] {
    OGB_MODE_SEVEN     = 2'b00,  // 7:1 video serializer, bits 6:0
    OGB_MODE_EIGHT     = 2'b01,  // generic_ddr_eight_mode, bits 7:0
    OGB_MODE_DUAL_FOUR = 2'b10   // generic_ddr_four_mode, two lanes
  } ogb_mode_t;

  // Word travelling through the pipeline with its gearing mode
  typedef struct packed {
    ogb_mode_t                  mode;
    logic [OGB_WORD_W-1:0]      data;
  } ogb_word_t;

  // Serial outputs toward the I/O buffer
  typedef struct packed {
    logic q;         // first_output_logic_slice / 7:1 / 8:1 stream
    logic q_second;  // second_output_logic_slice stream in dual mode
    logic active;    // A framed bit is being driven
  } ogb_serial_t;

endpackage : ogb_pkg

// *** rtl/ogb_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ogb_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import ogb_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0]   DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Handshakes use registered flags only, so full and empty are honest
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Pointer and occupancy update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= (next_count != DEPTH_C);
      out_valid <= (next_count != '0);
    end
  end

  // Storage is written only; no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : ogb_fifo
`default_nettype wire

// *** rtl/ogb_serializer.sv ***
// Output serializer gearbox: parallel core words to a serial bit stream
//
// Operation
// - The I/O cell carries its own serializer able to turn eight parallel bits into one stream.
// - The serializer runs as one 7:1 serializer, one 8:1 gearbox or two lock-step 4:1 gearboxes sharing one counter.
// - Data arrives on eight bits: 7:1 uses 6:0, 8:1 uses 7:0, dual 4:1 uses 3:0 and 7:4.
// - The first pipeline stage captures the parallel word from the core side.
// - The second stage hands each captured word over to the high-speed shifting registers.
// - The third stage shifts the word out bit by bit onto the serial output.
`timescale 1ns/1ps
`default_nettype none
module ogb_serializer (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire ogb_pkg::ogb_mode_t        mode,
  input  wire logic [ogb_pkg::OGB_WORD_W-1:0] in_data,
  input  wire logic                      in_valid,
  output logic                           in_ready,
  output var ogb_pkg::ogb_serial_t       serial_out,
  output logic                           word_start
);
  import ogb_pkg::*;

  // Stage 1 lives in the FIFO; it captures word and mode together
  ogb_word_t  in_word;
  ogb_word_t  fifo_word;
  logic       fifo_valid;
  logic       fifo_ready;

  // Stage 2 hold register
  ogb_word_t  hold;
  logic       hold_valid;
  ogb_word_t  next_hold;
  logic       next_hold_valid;

  // Stage 3 shifter state
  logic [OGB_WORD_W-1:0] shreg;
  logic [2:0]            bit_cnt;
  logic                  shifting;
  ogb_mode_t             sh_mode;
  logic [OGB_WORD_W-1:0] next_shreg;
  logic [2:0]            next_bit_cnt;
  logic                  next_shifting;
  ogb_mode_t             next_sh_mode;
  ogb_serial_t           next_serial;
  logic                  next_word_start;
  logic                  load;

  // Mask unused bits so seven-bit words never leak bit 7 onto the line
  assign in_word.mode = mode;
  assign in_word.data = (mode == OGB_MODE_SEVEN) ? {1'b0, in_data[6:0]}
                                                 : in_data;

  // Sixteen-word buffer absorbs core bursts; its ready stalls the core
  ogb_fifo #(
    .WIDTH ($bits(ogb_word_t)),
    .DEPTH (OGB_FIFO_DEPTH)
  ) u_stage1_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_word)
  );

  // Shifter takes a new word when idle or on the last bit of the old one
  assign load = hold_valid && (!shifting || bit_cnt == OGB_CNT_RST);

  // Hold refills whenever it is empty or handing its word over
  assign fifo_ready = !hold_valid || load;

  // Stage 2 next state
  always_comb begin
    next_hold       = hold;
    next_hold_valid = hold_valid;
    if (fifo_ready) begin
      next_hold_valid = fifo_valid;
      if (fifo_valid) begin
        next_hold = fifo_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold       <= '{mode: OGB_MODE_EIGHT, data: OGB_WORD_RST};
      hold_valid <= 1'b0;
    end else begin
      hold       <= next_hold;
      hold_valid <= next_hold_valid;
    end
  end

  // Stage 3 next state: shift, count and drive the serial bits
  always_comb begin
    next_shreg      = shreg;
    next_bit_cnt    = bit_cnt;
    next_shifting   = shifting;
    next_sh_mode    = sh_mode;
    next_word_start = 1'b0;
    next_serial     = '{q: OGB_IDLE_BIT, q_second: OGB_IDLE_BIT, active: 1'b0};
    if (load) begin
      next_shifting   = 1'b1;
      next_sh_mode    = hold.mode;
      next_word_start = 1'b1;
      next_serial.active   = 1'b1;
      next_serial.q        = hold.data[0];
      next_serial.q_second = OGB_IDLE_BIT;
      case (hold.mode)
        OGB_MODE_SEVEN: begin
          next_bit_cnt = OGB_LAST_SEVEN;
          next_shreg   = {1'b0, hold.data[7:1]};
        end
        OGB_MODE_DUAL_FOUR: begin
          // Two lock-step lanes sharing one counter, each shifting its own nibble
          next_bit_cnt         = OGB_LAST_FOUR;
          next_serial.q_second = hold.data[OGB_LANE_B_LSB];
          next_shreg           = {1'b0, hold.data[7:5], 1'b0, hold.data[3:1]};
        end
        default: begin
          next_bit_cnt = OGB_LAST_EIGHT;
          next_shreg   = {1'b0, hold.data[7:1]};
        end
      endcase
      // Count holds the bits still to come, so a full frame is LAST plus one
    end else if (shifting && bit_cnt != OGB_CNT_RST) begin
      next_serial.active = 1'b1;
      next_serial.q      = shreg[0];
      next_bit_cnt       = bit_cnt - 3'h1;
      if (sh_mode == OGB_MODE_DUAL_FOUR) begin
        next_serial.q_second = shreg[OGB_LANE_B_LSB];
        next_shreg           = {1'b0, shreg[7:5], 1'b0, shreg[3:1]};
      end else begin
        next_shreg = {1'b0, shreg[7:1]};
      end
    end else begin
      // Underrun: no word waiting, so the line falls back to idle
      next_shifting = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shreg      <= OGB_WORD_RST;
      bit_cnt    <= OGB_CNT_RST;
      shifting   <= 1'b0;
      sh_mode    <= OGB_MODE_EIGHT;
      serial_out <= '{q: OGB_IDLE_BIT, q_second: OGB_IDLE_BIT, active: 1'b0};
      word_start <= 1'b0;
    end else begin
      shreg      <= next_shreg;
      bit_cnt    <= next_bit_cnt;
      shifting   <= next_shifting;
      sh_mode    <= next_sh_mode;
      serial_out <= next_serial;
      word_start <= next_word_start;
    end
  end

endmodule : ogb_serializer
`default_nettype wire

// *** test/ogb_serializer_checker.sv ***
// Port checker for the output serializer gearbox
`timescale 1ns/1ps
`default_nettype none
module ogb_checker (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 in_valid,
  input wire logic                 in_ready,
  input wire ogb_pkg::ogb_serial_t serial_out,
  input wire logic                 word_start
);
  import ogb_pkg::*;
  logic [5:0] pend;
  logic [5:0] next_pend;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_lit4;
    serial_out.active [*4];
  endsequence
  // Words taken but not started; FIFO plus hold bounds it
  always_comb next_pend = reset ? 6'h00 : pend + 6'(in_valid & in_ready) - 6'(word_start);
  always_ff @(posedge clk) pend <= next_pend;
  a_reset_idle: assert property (disable iff (1'b0) reset |=> serial_out == '0 && !word_start)
    else $error("outputs not idle after reset");
  a_start_lit: assert property (word_start |-> s_lit4)
    else $error("frame shorter than four bits");
  a_idle_low: assert property (!serial_out.active |-> !serial_out.q && !serial_out.q_second)
    else $error("line not low while idle");
  a_take_start: assert property (in_valid && in_ready |-> ##[3:300] word_start)
    else $error("taken word never started");
  a_start_gap: assert property (word_start |=> !word_start [*3])
    else $error("word start too soon");
  a_rise_start: assert property ($rose(serial_out.active) |-> word_start)
    else $error("frame began without start");
  a_start_pend: assert property (word_start |-> pend != 6'h00)
    else $error("start without a taken word");
  a_pend_max: assert property (pend <= 6'h12)
    else $error("more words held than stages allow");
endmodule : ogb_checker
bind ogb_serializer ogb_checker u_chk (.clk(clk), .reset(reset), .in_valid(in_valid),
  .in_ready(in_ready), .serial_out(serial_out), .word_start(word_start));
`default_nettype wire

// *** test/ogb_core_model.sv ***
// Core-side word source feeding the serializer
`timescale 1ns/1ps
`default_nettype none
module ogb_core_model (
  input  wire logic                          clk,
  input  wire logic                          in_ready,
  output var  logic                          in_valid,
  output var  logic [ogb_pkg::OGB_WORD_W-1:0] in_data,
  output var  ogb_pkg::ogb_mode_t            mode
);
  import ogb_pkg::*;
  initial begin
    in_valid = 1'b0;
    in_data  = 8'hFF;
    mode     = OGB_MODE_EIGHT;
  end
  // Offer a word and hold it until the taking edge
  task automatic send(input logic [7:0] d, input ogb_mode_t m);
    in_valid <= 1'b1;
    in_data  <= d;
    mode     <= m;
    do @(posedge clk); while (in_ready !== 1'b1);
  endtask : send
  // Released bus shows the inverse, never a stale match
  task automatic idle();
    in_valid <= 1'b0;
    in_data  <= ~in_data;
  endtask : idle
endmodule : ogb_core_model
`default_nettype wire

// *** test/tb_output_serializer_gearbox.sv ***
// Self-checking bench for the output serializer gearbox
`timescale 1ns/1ps
`default_nettype none
module tb_output_serializer_gearbox;
  import ogb_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        in_valid;
  logic        in_ready;
  logic [7:0]  in_data;
  logic        word_start;
  ogb_mode_t   mode;
  ogb_serial_t serial_out;
  int          err_total = 0;
  int          n_tests = 0;
  int          refused = 0;
  always #5 clk = ~clk;
  ogb_serializer uut (.clk(clk), .reset(reset), .mode(mode), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .serial_out(serial_out), .word_start(word_start));
  ogb_core_model src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
    .mode(mode));
  // Offers turned away because the queue is full
  always @(posedge clk) if (in_valid === 1'b1 && in_ready === 1'b0 && !reset) refused++;
  task automatic chk(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] wd(input int i);
    return 8'(i) * 8'h25 + 8'h3C;
  endfunction : wd
  // Wait for the start, then follow every bit of the frame
  task automatic expect_word(input logic [7:0] d, input ogb_mode_t m);
    int k;
    int len;
    len = m == OGB_MODE_SEVEN ? 7 : m == OGB_MODE_DUAL_FOUR ? 4 : 8;
    k = 0;
    #1;
    while (word_start !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("word_start", 1'b1, word_start);
    for (int b = 0; b < len; b++) begin
      chk("q", d[b], serial_out.q);
      chk("q_second", m == OGB_MODE_DUAL_FOUR ? d[4+b] : 1'b0, serial_out.q_second);
      chk("active", 1'b1, serial_out.active);
      @(posedge clk);
      #1;
    end
  endtask : expect_word
  // Back-to-back words, modes alternating by index
  task automatic run(input string nm, input ogb_mode_t m0, input ogb_mode_t m1, input int n);
    @(posedge clk);
    fork
      begin
        for (int i = 0; i < n; i++) src.send(wd(i), i[0] ? m1 : m0);
        src.idle();
      end
      for (int i = 0; i < n; i++) expect_word(wd(i), i[0] ? m1 : m0);
    join
    chk("active", 1'b0, serial_out.active);
    $display("%s done", nm);
  endtask : run
  task automatic t_reset();
    repeat (4) @(posedge clk);
    #1;
    chk("serial_out", 1'b1, serial_out === 3'h0);
    chk("in_ready", 1'b0, in_ready);
    @(posedge clk) reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("in_ready", 1'b1, in_ready);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fill();
    refused = 0;
    run("t_fill", OGB_MODE_EIGHT, OGB_MODE_EIGHT, 24);
    chk("refusal", 1'b1, refused > 0);
  endtask : t_fill
  // Reset in mid-frame must leave the line idle
  task automatic t_mid();
    @(posedge clk);
    src.send(8'h81, OGB_MODE_EIGHT);
    src.idle();
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("serial_out", 1'b1, serial_out === 3'h0);
    @(posedge clk) reset <= 1'b0;
    run("t_mid", OGB_MODE_EIGHT, OGB_MODE_SEVEN, 2);
  endtask : t_mid
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    t_reset();
    run("t_seven", OGB_MODE_SEVEN, OGB_MODE_SEVEN, 3);
    run("t_dual", OGB_MODE_DUAL_FOUR, OGB_MODE_DUAL_FOUR, 3);
    run("t_mix", OGB_MODE_SEVEN, OGB_MODE_DUAL_FOUR, 4);
    t_fill();
    t_mid();
    close_out();
  end
endmodule : tb_output_serializer_gearbox
`default_nettype wire
